// ### hw/tcc_pkg.sv
// constants, command codes and carrier types for the temperature calibration block
package tcc_pkg;
  localparam int          NUM_PAGES        = 2;
  // command codes for the paged calibration registers
  localparam logic [7:0]  CMD_EXT_SCALE    = 8'hd9;
  localparam logic [7:0]  CMD_EXT_OFFSET   = 8'hda;
  localparam logic [7:0]  CMD_TEMPCO_SETUP = 8'hdc;
  // values after reset
  localparam logic [15:0] RST_EXT_SCALE    = 16'hba00;
  localparam logic [15:0] RST_EXT_OFFSET   = 16'h0000;
  localparam logic [7:0]  RST_TEMPCO_SETUP = 8'h27;
  // linear-11 field layout
  localparam int          L11_EXP_MSB      = 15;
  localparam int          L11_EXP_LSB      = 11;
  localparam int          L11_MAN_MSB      = 10;
  // tempco setup field layout
  localparam int          SRC_SEL_BIT      = 7;
  localparam int          FACTOR_MSB       = 6;
  // fixed point: internal values q8, temperatures q4
  localparam int          FIX_FRAC         = 8;
  localparam int          TEMP_FRAC        = 4;
  localparam int          REF_TEMP_C       = 25;
  localparam int          FACTOR_UNIT_PPM  = 100;
  localparam longint      PPM_ONE          = 1000000;
  localparam int          DIV_WIDTH        = 32;
  localparam logic [5:0]  DIV_STEPS        = 6'd32;
  localparam int          DIV_LATENCY      = 33;

  // one register command from the management host
  typedef struct packed {
    logic        write;
    logic        page;
    logic [7:0]  code;
    logic [15:0] wdata;
  } tcc_cmd_s;

  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_DIV  = 1'b1
  } tcc_state_e;
endpackage : tcc_pkg

// ### hw/tcc_divider.sv
// unsigned restoring serial divider, one quotient bit per clock
`timescale 1ns/1ns
`default_nettype none
module tcc_divider (
  input  wire logic                           i_clk,
  input  wire logic                           i_rst_n,
  input  wire logic                           i_start,
  input  wire logic [tcc_pkg::DIV_WIDTH-1:0]  i_dividend,
  input  wire logic [tcc_pkg::DIV_WIDTH-1:0]  i_divisor,
  output logic                                o_done,
  output logic [tcc_pkg::DIV_WIDTH-1:0]       o_quotient
);
  import tcc_pkg::*;

  logic [DIV_WIDTH:0]   rem_q;
  logic [DIV_WIDTH-1:0] quo_q;
  logic [DIV_WIDTH-1:0] div_q;
  logic [5:0]           cnt_q;
  logic                 done_q;
  logic [DIV_WIDTH:0]   rem_sh;
  logic                 fits;

  ////////////////////////////////////////////////////////////////////////////
  // trial subtraction of the shifted remainder
  assign rem_sh = {rem_q[DIV_WIDTH-1:0], quo_q[DIV_WIDTH-1]};
  assign fits   = rem_sh >= {1'b0, div_q};

  // iteration; a zero divisor yields an all-ones quotient (saturation)
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rem_q  <= '0;
      quo_q  <= '0;
      div_q  <= '0;
      cnt_q  <= '0;
      done_q <= 1'b0;
    end else if (i_start) begin
      rem_q  <= '0;
      quo_q  <= i_dividend;
      div_q  <= i_divisor;
      cnt_q  <= DIV_STEPS;
      done_q <= 1'b0;
    end else begin
      done_q <= (cnt_q == 6'd1);
      if (cnt_q != 6'd0) begin
        cnt_q <= cnt_q - 6'd1;
        rem_q <= fits ? rem_sh - {1'b0, div_q} : rem_sh;
        quo_q <= {quo_q[DIV_WIDTH-2:0], fits};
      end
    end
  end

  assign o_done     = done_q;
  assign o_quotient = quo_q;
endmodule : tcc_divider
`default_nettype wire

// ### hw/tcc_core.sv
// paged external temperature calibration and current-sense tempco correction
`timescale 1ns/1ns
`default_nettype none
module tcc_core (
  input  wire logic                               i_clk,
  input  wire logic                               i_rst_n,
  input  wire logic                               i_cmd_valid,
  input  wire tcc_pkg::tcc_cmd_s                  i_cmd,
  output logic                                    o_cmd_ack,
  output logic                                    o_cmd_err,
  output logic [15:0]                             o_cmd_rdata,
  input  wire logic                               i_meas_valid,
  input  wire logic                               i_meas_page,
  input  wire logic signed [15:0]                 i_ext_temp_raw,
  output logic                                    o_meas_ready,
  input  wire logic signed [15:0]                 i_int_temp,
  input  wire logic [tcc_pkg::NUM_PAGES-1:0][15:0] i_sense_gain,
  output logic                                    o_ext_temp_valid,
  output logic                                    o_ext_temp_page,
  output logic [tcc_pkg::NUM_PAGES-1:0][15:0]     o_ext_temp,
  output logic [tcc_pkg::NUM_PAGES-1:0][31:0]     o_sense_resistance,
  output logic [tcc_pkg::NUM_PAGES-1:0][31:0]     o_tempco_ppm
);
  import tcc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // linear-11 word to signed q8 fixed point
  function automatic logic signed [31:0] lin11_q8(input logic [15:0] w);
    logic signed [31:0] man;
    logic signed [6:0]  sh;
    man = 32'($signed(w[L11_MAN_MSB:0]));
    sh  = 7'($signed(w[L11_EXP_MSB:L11_EXP_LSB])) + 7'(FIX_FRAC);
    if (sh >= 7'sd0) begin
      return man <<< sh[4:0];
    end else begin
      return man >>> 5'(-sh);
    end
  endfunction : lin11_q8

  function automatic logic [31:0] mag32(input logic signed [31:0] v);
    return v[31] ? 32'(-v) : v;
  endfunction : mag32

  ////////////////////////////////////////////////////////////////////////////
  // register file
  logic [NUM_PAGES-1:0][15:0] scale_q;
  logic [NUM_PAGES-1:0][15:0] offset_q;
  logic [NUM_PAGES-1:0][7:0]  tcset_q;
  logic                       wr_en;
  logic                       hit;

  assign wr_en = i_cmd_valid && i_cmd.write;
  assign hit   = (i_cmd.code == CMD_EXT_SCALE) || (i_cmd.code == CMD_EXT_OFFSET)
              || (i_cmd.code == CMD_TEMPCO_SETUP);

  // register writes, paged
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      scale_q  <= {NUM_PAGES{RST_EXT_SCALE}};
      offset_q <= {NUM_PAGES{RST_EXT_OFFSET}};
      tcset_q  <= {NUM_PAGES{RST_TEMPCO_SETUP}};
    end else if (wr_en) begin
      unique case (i_cmd.code)
        CMD_EXT_SCALE:    scale_q[i_cmd.page]  <= i_cmd.wdata;
        CMD_EXT_OFFSET:   offset_q[i_cmd.page] <= i_cmd.wdata;
        CMD_TEMPCO_SETUP: tcset_q[i_cmd.page]  <= i_cmd.wdata[7:0];
        default:          ;
      endcase
    end
  end

  // command answer one cycle after the request
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_cmd_ack   <= 1'b0;
      o_cmd_err   <= 1'b0;
      o_cmd_rdata <= '0;
    end else begin
      o_cmd_ack   <= i_cmd_valid;
      o_cmd_err   <= i_cmd_valid && !hit;
      o_cmd_rdata <= '0;
      if (i_cmd_valid && !i_cmd.write) begin
        unique case (i_cmd.code)
          CMD_EXT_SCALE:    o_cmd_rdata <= scale_q[i_cmd.page];
          CMD_EXT_OFFSET:   o_cmd_rdata <= offset_q[i_cmd.page];
          CMD_TEMPCO_SETUP: o_cmd_rdata <= {8'h00, tcset_q[i_cmd.page]};
          default:          o_cmd_rdata <= '0;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // external temperature calibration through the serial divider
  tcc_state_e         state_q;
  logic               page_q;
  logic               neg_q;
  logic               start;
  logic               div_done;
  logic [31:0]        quotient;
  logic signed [31:0] scale_fix;
  logic signed [31:0] raw_fix;
  logic signed [31:0] quo_signed;
  logic signed [31:0] offs_q4;

  assign start        = i_meas_valid && (state_q == ST_IDLE);
  assign o_meas_ready = (state_q == ST_IDLE);
  assign scale_fix    = lin11_q8(scale_q[i_meas_page]);
  // raw q4 shifted to q12 so that dividing by q8 scale leaves q4
  assign raw_fix      = 32'(i_ext_temp_raw) <<< FIX_FRAC;
  assign quo_signed   = neg_q ? 32'(-$signed(quotient)) : $signed(quotient);
  assign offs_q4      = lin11_q8(offset_q[page_q]) >>> (FIX_FRAC - TEMP_FRAC);

  tcc_divider u_div (
    .i_clk      (i_clk),
    .i_rst_n    (i_rst_n),
    .i_start    (start),
    .i_dividend (mag32(raw_fix)),
    .i_divisor  (mag32(scale_fix)),
    .o_done     (div_done),
    .o_quotient (quotient)
  );

  // sequencing; measurements offered while busy are held off by ready
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q <= ST_IDLE;
      page_q  <= 1'b0;
      neg_q   <= 1'b0;
    end else begin
      unique case (state_q)
        ST_IDLE: if (start) begin
          state_q <= ST_DIV;
          page_q  <= i_meas_page;
          neg_q   <= i_ext_temp_raw[15] ^ scale_fix[31];
        end
        ST_DIV: if (div_done) begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // reported value: raw times reciprocal of scale, plus offset
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_ext_temp       <= '0;
      o_ext_temp_valid <= 1'b0;
      o_ext_temp_page  <= 1'b0;
    end else begin
      o_ext_temp_valid <= (state_q == ST_DIV) && div_done;
      if ((state_q == ST_DIV) && div_done) begin
        o_ext_temp[page_q] <= 16'(quo_signed + offs_q4);
        o_ext_temp_page    <= page_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // tempco correction of the current-sense resistance, every cycle per page
  logic signed [15:0] temp_sel  [NUM_PAGES];
  logic signed [31:0] corr_prod [NUM_PAGES];

  // unpacked per page so each element keeps its sign below 25 degrees
  always_comb begin
    for (int p = 0; p < NUM_PAGES; p++) begin
      // source select; external input must already be enabled by the host
      temp_sel[p]  = tcset_q[p][SRC_SEL_BIT] ? o_ext_temp[p] : i_int_temp;
      // factor times (t - 25) times ppm unit, still q4 in temperature
      corr_prod[p] = 32'($signed({1'b0, tcset_q[p][FACTOR_MSB:0]}))
                   * (32'(temp_sel[p]) - 32'(REF_TEMP_C <<< TEMP_FRAC))
                   * 32'(FACTOR_UNIT_PPM);
    end
  end

  // resistance estimate rises with temperature; reading divided by it cancels drift
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_sense_resistance <= '0;
      o_tempco_ppm       <= '0;
    end else begin
      for (int p = 0; p < NUM_PAGES; p++) begin
        o_tempco_ppm[p]       <= 32'(-(corr_prod[p] >>> TEMP_FRAC));
        o_sense_resistance[p] <= 32'((64'(lin11_q8(i_sense_gain[p]))
                               * (64'(PPM_ONE <<< TEMP_FRAC) + 64'(corr_prod[p])))
                               / 64'(PPM_ONE <<< TEMP_FRAC));
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  // cycles from the end of the eight busy cycles to the sampled result pulse
  localparam int DLAT = DIV_LATENCY - 7;

  unity_decode_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    start && scale_q[i_meas_page] == RST_EXT_SCALE |-> scale_fix == 32'sd256)
    else $error("unity scale code does not decode to one");

  lin11_exp_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    start && scale_q[i_meas_page] == 16'hf803 |-> scale_fix == 32'sd384)
    else $error("linear-11 decode wrong");

  offset_write_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    wr_en && i_cmd.code == CMD_EXT_OFFSET |=> offset_q[$past(i_cmd.page)] == $past(i_cmd.wdata))
    else $error("offset write not stored");

  offset_stable_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !(wr_en && i_cmd.code == CMD_EXT_OFFSET) |=> $stable(offset_q))
    else $error("offset changed without write");

  tcset_read_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_cmd_valid && !i_cmd.write && i_cmd.code == CMD_TEMPCO_SETUP
    |=> o_cmd_ack && !o_cmd_err && o_cmd_rdata == {8'h00, $past(tcset_q[i_cmd.page])})
    else $error("tempco setup read wrong");

  calib_latency_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    start |=> !o_meas_ready [*8] ##DLAT o_ext_temp_valid && o_ext_temp_page == page_q)
    else $error("calibrated temperature not on time");

  src_select_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    tcset_q[0][SRC_SEL_BIT] == 1'b0 && $stable(i_int_temp) && $stable(tcset_q[0])
    && i_int_temp == 16'sd400 |=> o_tempco_ppm[0] == 32'sd0)
    else $error("internal source not used at 25 degrees");

  neg_corr_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    |tcset_q[1][FACTOR_MSB:0] && temp_sel[1] > 16'sd400 |=> $signed(o_tempco_ppm[1]) < 0)
    else $error("tempco correction not negative above reference");

  sres_ref_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    corr_prod[0] == 32'sd0 |=> o_sense_resistance[0] == $past(lin11_q8(i_sense_gain[0])))
    else $error("sense resistance not equal to gain at reference");
endmodule : tcc_core
`default_nettype wire

// ### verification/tcc_host.sv
// host-side command master model for the paged calibration registers
`timescale 1ns/1ns
`default_nettype none
module tcc_host (
  input  wire logic              i_clk,
  input  wire logic              i_cmd_ack,
  input  wire logic              i_cmd_err,
  input  wire logic [15:0]       i_cmd_rdata,
  output var  logic              o_cmd_valid,
  output var  tcc_pkg::tcc_cmd_s o_cmd
);
  import tcc_pkg::*;
  logic ext_diode_en = 1'b0; // diode input switched on by the host
  initial begin
    o_cmd_valid = 1'b0;
    o_cmd = '0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // host turns the diode input on before using it as source
  task automatic enable_ext;
    ext_diode_en = 1'b1;
  endtask : enable_ext
  // one command, raised for one cycle, answer sampled the cycle after
  task automatic xfer(input logic wr, input logic pg, input logic [7:0] c,
                      input logic [15:0] wd, output logic a, output logic e,
                      output logic [15:0] r);
    logic [15:0] w;
    w = wd;
    if (wr && c == CMD_TEMPCO_SETUP) begin
      if (!ext_diode_en) w[SRC_SEL_BIT] = 1'b0;
      if (w[FACTOR_MSB:0] > 7'd63) w[FACTOR_MSB:0] = 7'd63;
    end
    @(posedge i_clk);
    o_cmd_valid <= 1'b1;
    o_cmd       <= '{write: wr, page: pg, code: c, wdata: w};
    @(posedge i_clk);
    o_cmd_valid <= 1'b0;
    o_cmd       <= ~o_cmd; // released lines do not keep the last value
    #1;
    a = i_cmd_ack;
    e = i_cmd_err;
    r = i_cmd_rdata;
  endtask : xfer
endmodule : tcc_host
`default_nettype wire

// ### verification/tcc_core_tb.sv
// self-checking bench for the calibration and tempco correction block
`timescale 1ns/1ns
`default_nettype none
module tcc_core_tb;
  import tcc_pkg::*;
  logic               clk = 1'b0, rst_n = 1'b0, cmd_valid, ack, err, ready, xv, xp;
  logic               meas_valid = 1'b0, meas_page = 1'b0;
  tcc_cmd_s           cmd;
  logic [15:0]        rdata;
  logic signed [15:0] ext_raw = '0, itemp = '0;
  logic [1:0][15:0]   gain = '0, xt;
  logic [1:0][31:0]   sres, tppm;
  int                 fail_count = 0, checks_done = 0;
  always #4 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////////
  tcc_host i_tcc_host (.i_clk(clk), .i_cmd_ack(ack), .i_cmd_err(err),
    .i_cmd_rdata(rdata), .o_cmd_valid(cmd_valid), .o_cmd(cmd));
  tcc_core i_tcc_core (.i_clk(clk), .i_rst_n(rst_n), .i_cmd_valid(cmd_valid), .i_cmd(cmd),
    .o_cmd_ack(ack), .o_cmd_err(err), .o_cmd_rdata(rdata), .i_meas_valid(meas_valid),
    .i_meas_page(meas_page), .i_ext_temp_raw(ext_raw), .o_meas_ready(ready),
    .i_int_temp(itemp), .i_sense_gain(gain), .o_ext_temp_valid(xv), .o_ext_temp_page(xp),
    .o_ext_temp(xt), .o_sense_resistance(sres), .o_tempco_ppm(tppm));
  ////////////////////////////////////////////////////////////////////////////////
  // linear-11 word to q8
  function automatic longint l11(input logic [15:0] w);
    longint m;
    int     e;
    m = longint'(signed'(w[10:0]));
    e = int'(signed'(w[15:11])) + 8;
    if (e >= 0) return m <<< e;
    return m >>> (-e);
  endfunction : l11
  function automatic logic [15:0] calib(input longint r, input logic [15:0] s, o);
    longint q;
    q = (r < 0 ? -r : r) * 256 / l11(s);
    if (r < 0) q = -q;
    return 16'(q + (l11(o) >>> 4));
  endfunction : calib
  function automatic logic [31:0] sres_exp(input logic [15:0] g, input longint t, cf);
    return 32'(l11(g) * (16000000 + cf * (t - 400) * 100) / 16000000);
  endfunction : sres_exp
  function automatic logic [31:0] ppm_exp(input longint t, cf);
    return 32'(-(cf * 100 * (t - 400) / 16));
  endfunction : ppm_exp
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e, g);
    checks_done++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
      fail_count++;
    end
  endtask : chk
  task automatic cmd_chk(input logic wr, pg, input logic [7:0] c,
                         input logic [15:0] wd, input logic ee, input logic [15:0] er);
    logic        a, e;
    logic [15:0] r;
    i_tcc_host.xfer(wr, pg, c, wd, a, e, r);
    chk("ack", 1, a);
    chk("err", ee, e);
    if (!wr) chk("rdata", er, r);
  endtask : cmd_chk
  // offer one raw sample and wait for its result
  task automatic meas(input logic pg, input logic [15:0] r);
    int n;
    n = 0;
    @(posedge clk);
    meas_valid <= 1'b1;
    meas_page  <= pg;
    ext_raw    <= r;
    @(posedge clk);
    meas_valid <= 1'b0;
    ext_raw    <= ~r;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (xv !== 1'b1 && n < 100);
    chk("latency", 33, n);
    chk("page", pg, xp);
  endtask : meas
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_of_test
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #(8 * 20000);
    fail_count++;
    end_of_test();
  end
  initial begin
    logic [15:0]        sc[4], w, off;
    logic signed [15:0] r;
    logic [6:0]         cf;
    logic               pg;
    int                 t;
    sc = '{16'hba00, 16'h0002, 16'hf803, 16'h0001};
    void'($urandom(28));
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    for (int p = 0; p < 2; p++) begin
      cmd_chk(1, p[0], 8'hdb, 16'hffff, 1, 0);
      cmd_chk(0, p[0], 8'hd9, 0, 0, 16'hba00);
      cmd_chk(0, p[0], 8'hda, 0, 0, 16'h0000);
      cmd_chk(0, p[0], 8'hdc, 0, 0, 16'h0027);
      cmd_chk(0, p[0], 8'h88 ^ 8'($urandom_range(7)), 0, 1, 0);
    end
    $display("test reset_values done");
    for (int i = 0; i < 4; i++) begin
      pg = 1'($urandom);
      w = 16'($urandom);
      cmd_chk(1, pg, 8'hda, w, 0, 0);
      cmd_chk(0, pg, 8'hda, 0, 0, w);
      w = {8'($urandom), 1'b0, 7'($urandom_range(63))};
      cmd_chk(1, pg, 8'hdc, w, 0, 0);
      cmd_chk(0, pg, 8'hdc, 0, 0, {8'h00, w[7:0]});
    end
    $display("test read_write done");
    for (int i = 0; i < 8; i++) begin
      pg = 1'($urandom);
      off = {5'h00, 11'($urandom_range(200)) - 11'd100};
      r = 16'($urandom_range(4000)) - 16'sd2000;
      if (i == 0) r = 16'sh8000 >>> 5;
      cmd_chk(1, pg, 8'hd9, sc[i % 4], 0, 0);
      cmd_chk(1, pg, 8'hda, off, 0, 0);
      w = xt[~pg];
      meas(pg, r);
      chk("ext_temp", calib(r, sc[i % 4], off), xt[pg]);
      chk("held", w, xt[~pg]);
    end
    $display("test calibration done");
    for (int i = 0; i < 6; i++) begin
      pg = 1'($urandom);
      cf = (i == 0) ? 7'd63 : 7'($urandom_range(63));
      t = 16 * $urandom_range(120, 26);
      // corner cases: exactly 25 degrees on page 0, then below 25 degrees
      if (i == 1) begin
        pg = 1'b0;
        t  = 400;
      end
      if (i == 2) t = 16 * 10;
      @(posedge clk);
      gain[pg] <= {5'h00, 11'($urandom_range(1000, 1))};
      itemp    <= 16'(t);
      cmd_chk(1, pg, 8'hdc, {9'h000, cf}, 0, 0);
      repeat (4) @(posedge clk);
      #1;
      chk("sense_res", sres_exp(gain[pg], t, cf), sres[pg]);
      chk("tempco_ppm", ppm_exp(t, cf), tppm[pg]);
    end
    $display("test internal_source done");
    i_tcc_host.enable_ext();
    t = 16 * 60;
    cf = 7'd39;
    cmd_chk(1, 1'b1, 8'hd9, 16'hba00, 0, 0);
    cmd_chk(1, 1'b1, 8'hda, 16'h0000, 0, 0);
    cmd_chk(1, 1'b1, 8'hdc, {8'h00, 1'b1, cf}, 0, 0);
    @(posedge clk);
    itemp   <= '0;
    gain[1] <= 16'h0123;
    meas(1'b1, 16'(t));
    repeat (4) @(posedge clk);
    #1;
    chk("ext_ppm", ppm_exp(t, cf), tppm[1]);
    chk("ext_sres", sres_exp(gain[1], t, cf), sres[1]);
    $display("test external_source done");
    end_of_test();
  end
endmodule : tcc_core_tb
`default_nettype wire
